// [logic/lucc_regs.sv]
// Per-channel control register bank of the line unit, AHB-Lite slave
// Behaviour
// - Receive termination bit: 0 high impedance, 1 internal termination; reset high impedance.
// - Transmit termination bit: 0 high impedance, 1 internal termination; reset high impedance.
// - Two-bit impedance field: 100, 110, 75, 120 ohm for coding_select 0..3.
// - Receive jitter attenuator enabled when its bit is 1, off by default.
// - Transmit jitter attenuator enabled when its bit is 1, off by default.
// - E1: bandwidth bit picks 10 Hz or 1.5 Hz; T1 fixed at 3 Hz.
// - FIFO depth bit picks 32 or 64 bits; delay is half the depth.
// - Pattern invert bit sends the quasi-random pattern with inverted polarity.
// - Test field: 0xx none, 100 quasi-random, 101 ones, 110 loop-up, 111 loop-down.
// - Transmitter powered only when its bit and the global power pin are high.
// - Loopback field: 0xx none, 100 dual, 101 analog, 110 remote, 111 digital.
// - Loop code detect: off, loop-up, loop-down, automatic for coding_select 0..3.
// - Single rail only: coding bit 0 gives HDB3 or B8ZS, 1 gives AMI.
// - Resistor field declares external resistor: none, 240, 210, 150 ohm.
// - Each rising transition of violation bit inserts one bipolar violation.
// - Each rising transition of error bit inserts one bit error.
// - Insert bits are sampled on rising edges of the transmit clock.
// - Per-channel pattern type bit: 0 quasi-random, 1 pseudo-random.
`timescale 1ns/1ps

module lucc_regs #(
  parameter int unsigned NUM_CH = lucc_pkg::NUM_CH
) (
  input  wire logic                          hclk,
  input  wire logic                          hresetn,
  input  wire logic                          hsel,
  input  wire logic [lucc_pkg::ADDR_W-1:0]   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [lucc_pkg::DATA_W-1:0]   hwdata,
  input  wire logic                          hready,
  output logic      [lucc_pkg::DATA_W-1:0]   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire logic                          tx_power_pin,
  input  wire logic                          tx_clock,
  input  wire logic [NUM_CH-1:0]             e1_mode,
  input  wire logic [NUM_CH-1:0]             single_rail,
  output logic      [NUM_CH-1:0]             rx_term_select,
  output logic      [NUM_CH-1:0]             tx_term_select,
  output logic      [2*NUM_CH-1:0]           line_impedance_select,
  output logic      [NUM_CH-1:0]             rx_jitter_atten_enable,
  output logic      [NUM_CH-1:0]             tx_jitter_atten_enable,
  output logic      [2*NUM_CH-1:0]           jitter_bw_code,
  output logic      [NUM_CH-1:0]             fifo_depth_select,
  output logic      [6*NUM_CH-1:0]           ja_fifo_delay,
  output logic      [NUM_CH-1:0]             pattern_invert,
  output logic      [3*NUM_CH-1:0]           tx_test_pattern_select,
  output logic      [NUM_CH-1:0]             pattern_type_select,
  output logic      [NUM_CH-1:0]             tx_power_enable,
  output logic      [3*NUM_CH-1:0]           loopback_select,
  output logic      [2*NUM_CH-1:0]           loop_code_detect_select,
  output logic      [2*NUM_CH-1:0]           line_code,
  output logic      [2*NUM_CH-1:0]           rx_resistor_select,
  output logic      [NUM_CH-1:0]             insert_violation_pulse,
  output logic      [NUM_CH-1:0]             insert_bit_error_pulse
);
  import lucc_pkg::*;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Returns {hit, channel[3:0], register[1:0]}
  function automatic logic [6:0] decode(input logic [ADDR_W-1:0] a);
    logic       hit;
    logic [3:0] ch;
    hit = (a[ADDR_W-1:ADDR_TOP_LO] == '0) && (a[ADDR_PAD_HI:ADDR_PAD_LO] == 2'h0);
    ch  = a[ADDR_CH_HI:ADDR_CH_LO];
    hit = hit && (32'(ch) < NUM_CH);
    return {hit, ch, a[ADDR_REG_HI:ADDR_REG_LO]};
  endfunction

  function automatic logic is_status(input logic [ADDR_W-1:0] a);
    return (a[ADDR_W-1:ADDR_TOP_LO] == '0) && (a[ADDR_IDX_HI:ADDR_IDX_LO] == IDX_TX_STATUS);
  endfunction

  // ****************************************************************
  // AHB-Lite transfer tracking
  // ****************************************************************
  logic              addr_phase;
  logic [ADDR_W-1:0] addr_ff;
  logic              wr_pend_ff;
  logic              rd_pend_ff;
  logic              hreadyout_ff;
  logic [DATA_W-1:0] hrdata_ff;
  logic              hresp_ff;
  logic [6:0]        dec;
  logic              wr_go;

  assign addr_phase = hsel && hready && ((htrans == HTRANS_NONSEQ) || (htrans == HTRANS_SEQ));
  assign dec        = decode(addr_ff);
  assign wr_go      = wr_pend_ff && dec[6];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_ff    <= '0;
      wr_pend_ff <= 1'b0;
    end else begin
      wr_pend_ff <= addr_phase && hwrite;
      if (addr_phase) begin
        addr_ff <= haddr;
      end
    end
  end

  // Reads take one wait state so a write just ahead is always seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_pend_ff   <= 1'b0;
      hreadyout_ff <= 1'b1;
    end else begin
      rd_pend_ff   <= addr_phase && !hwrite;
      hreadyout_ff <= !(addr_phase && !hwrite);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_ff <= HRESP_OKAY;
    end else begin
      hresp_ff <= HRESP_OKAY;
    end
  end

  // ****************************************************************
  // Channel storage
  // ****************************************************************
  logic [REG_W-1:0] pat_ff [NUM_CH];
  logic [REG_W-1:0] tjc_ff [NUM_CH];
  logic [REG_W-1:0] tpl_ff [NUM_CH];
  logic [REG_W-1:0] lci_ff [NUM_CH];

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_store
      logic sel;
      assign sel = wr_go && (dec[5:2] == 4'(gc));

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pat_ff[gc] <= CFG_RESET;
        end else if (sel && (dec[1:0] == IDX_PATTERN_TYPE)) begin
          pat_ff[gc] <= hwdata[REG_W-1:0] & MASK_PATTERN_TYPE;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          tjc_ff[gc] <= CFG_RESET;
        end else if (sel && (dec[1:0] == IDX_TERM_JITTER)) begin
          tjc_ff[gc] <= hwdata[REG_W-1:0] & MASK_TERM_JITTER;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          tpl_ff[gc] <= CFG_RESET;
        end else if (sel && (dec[1:0] == IDX_TEST_POWER)) begin
          tpl_ff[gc] <= hwdata[REG_W-1:0] & MASK_TEST_POWER;
        end
      end

      // Unused low bit stays zero
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          lci_ff[gc] <= CFG_RESET;
        end else if (sel && (dec[1:0] == IDX_LOOPCODE)) begin
          lci_ff[gc] <= hwdata[REG_W-1:0] & MASK_LOOPCODE;
        end
      end

      // Plain configuration fields straight from storage
      assign rx_term_select[gc]         = tjc_ff[gc][B_RX_TERM];
      assign tx_term_select[gc]         = tjc_ff[gc][B_TX_TERM];
      assign line_impedance_select[2*gc +: 2] =
        tjc_ff[gc][B_IMPED_HI:B_IMPED_LO];
      assign rx_jitter_atten_enable[gc] = tjc_ff[gc][B_RX_JA];
      assign tx_jitter_atten_enable[gc] = tjc_ff[gc][B_TX_JA];
      assign fifo_depth_select[gc]      = tjc_ff[gc][B_FIFO_DEPTH];
      assign pattern_invert[gc]         = tpl_ff[gc][B_PAT_INVERT];
      assign tx_test_pattern_select[3*gc +: 3] =
        tpl_ff[gc][B_TEST_HI:B_TEST_LO];
      assign pattern_type_select[gc]    = pat_ff[gc][B_PATTERN_TYPE];
      assign loopback_select[3*gc +: 3] = tpl_ff[gc][B_LOOP_HI:B_LOOP_LO];
      assign loop_code_detect_select[2*gc +: 2] =
        lci_ff[gc][B_DETECT_HI:B_DETECT_LO];
      assign rx_resistor_select[2*gc +: 2] = lci_ff[gc][B_RES_HI:B_RES_LO];
    end
  endgenerate

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Three stages; a level is taken only when stages two and three agree
  logic pin_s1_ff;
  logic pin_s2_ff;
  logic pin_s3_ff;
  logic pin_lvl_ff;
  logic tck_s1_ff;
  logic tck_s2_ff;
  logic tck_s3_ff;
  logic tck_lvl_ff;
  logic tck_rise;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_ff  <= 1'b0;
      pin_s2_ff  <= 1'b0;
      pin_s3_ff  <= 1'b0;
      pin_lvl_ff <= 1'b0;
    end else begin
      pin_s1_ff <= tx_power_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      if (pin_s2_ff == pin_s3_ff) begin
        pin_lvl_ff <= pin_s3_ff;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tck_s1_ff  <= 1'b0;
      tck_s2_ff  <= 1'b0;
      tck_s3_ff  <= 1'b0;
      tck_lvl_ff <= 1'b0;
    end else begin
      tck_s1_ff <= tx_clock;
      tck_s2_ff <= tck_s1_ff;
      tck_s3_ff <= tck_s2_ff;
      if (tck_s2_ff == tck_s3_ff) begin
        tck_lvl_ff <= tck_s3_ff;
      end
    end
  end

  // Transmit clock must be well below half of hclk to be seen
  assign tck_rise = tck_s2_ff && tck_s3_ff && !tck_lvl_ff;

  // ****************************************************************
  // Derived per-channel outputs
  // ****************************************************************
  logic [NUM_CH-1:0]   pwr_ff;
  logic [2*NUM_CH-1:0] jbw_ff;
  logic [6*NUM_CH-1:0] dly_ff;
  logic [2*NUM_CH-1:0] lcode_ff;
  logic [NUM_CH-1:0]   viol_smp_ff;
  logic [NUM_CH-1:0]   err_smp_ff;
  logic [NUM_CH-1:0]   viol_pls_ff;
  logic [NUM_CH-1:0]   err_pls_ff;

  generate
    for (gc = 0; gc < NUM_CH; gc++) begin : g_derive
      // A low pin forces every transmitter off
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pwr_ff[gc] <= 1'b0;
        end else begin
          pwr_ff[gc] <= tpl_ff[gc][B_TX_POWER] && pin_lvl_ff;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          jbw_ff[2*gc +: 2] <= JBW_10HZ;
        end else if (!e1_mode[gc]) begin
          jbw_ff[2*gc +: 2] <= JBW_3HZ;
        end else begin
          jbw_ff[2*gc +: 2] <= tjc_ff[gc][B_JA_BW] ? JBW_1P5HZ : JBW_10HZ;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          dly_ff[6*gc +: 6] <= DLY_SHALLOW;
        end else begin
          dly_ff[6*gc +: 6] <= tjc_ff[gc][B_FIFO_DEPTH] ? DLY_DEEP : DLY_SHALLOW;
        end
      end

      // Coding bit has no effect on a dual rail channel
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          lcode_ff[2*gc +: 2] <= LCODE_DUAL;
        end else if (!single_rail[gc]) begin
          lcode_ff[2*gc +: 2] <= LCODE_DUAL;
        end else if (lci_ff[gc][B_CODING]) begin
          lcode_ff[2*gc +: 2] <= LCODE_AMI;
        end else begin
          lcode_ff[2*gc +: 2] <= e1_mode[gc] ? LCODE_HDB3 : LCODE_B8ZS;
        end
      end

      // Insert bits sampled only on transmit clock edges; a 1 already
      // held gives no new insertion until a 0 has been sampled
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          viol_smp_ff[gc] <= 1'b0;
          err_smp_ff[gc]  <= 1'b0;
          viol_pls_ff[gc] <= 1'b0;
          err_pls_ff[gc]  <= 1'b0;
        end else if (tck_rise) begin
          viol_smp_ff[gc] <= lci_ff[gc][B_INS_VIOL];
          err_smp_ff[gc]  <= lci_ff[gc][B_INS_ERR];
          viol_pls_ff[gc] <= lci_ff[gc][B_INS_VIOL] && !viol_smp_ff[gc];
          err_pls_ff[gc]  <= lci_ff[gc][B_INS_ERR] && !err_smp_ff[gc];
        end else begin
          viol_pls_ff[gc] <= 1'b0;
          err_pls_ff[gc]  <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Read path
  // ****************************************************************
  logic [DATA_W-1:0] rd_word;

  always_comb begin
    rd_word = '0;
    if (is_status(addr_ff)) begin
      rd_word[NUM_CH-1:0]  = pwr_ff;
      rd_word[B_STAT_PIN]  = pin_lvl_ff;
    end else if (dec[6]) begin
      case (dec[1:0])
        IDX_PATTERN_TYPE: rd_word[REG_W-1:0] = pat_ff[dec[5:2]];
        IDX_TERM_JITTER:  rd_word[REG_W-1:0] = tjc_ff[dec[5:2]];
        IDX_TEST_POWER:   rd_word[REG_W-1:0] = tpl_ff[dec[5:2]];
        IDX_LOOPCODE:     rd_word[REG_W-1:0] = lci_ff[dec[5:2]];
        default:          rd_word = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= '0;
    end else if (rd_pend_ff) begin
      hrdata_ff <= rd_word;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign hrdata                 = hrdata_ff;
  assign hreadyout              = hreadyout_ff;
  assign hresp                  = hresp_ff;
  assign tx_power_enable        = pwr_ff;
  assign jitter_bw_code         = jbw_ff;
  assign ja_fifo_delay          = dly_ff;
  assign line_code              = lcode_ff;
  assign insert_violation_pulse = viol_pls_ff;
  assign insert_bit_error_pulse = err_pls_ff;

endmodule // lucc_regs

// [logic/lucc_pkg.sv]
// Constants, register map and field layout of the line unit channel control bank
package lucc_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned NUM_CH       = 14;
  localparam int unsigned REG_W        = 8;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned ADDR_W       = 32;

  // ****************************************************************
  // Register indices (byte address = 4 * index)
  // ****************************************************************
  localparam logic [1:0] IDX_PATTERN_TYPE = 2'h0;
  localparam logic [1:0] IDX_TERM_JITTER  = 2'h1;
  localparam logic [1:0] IDX_TEST_POWER   = 2'h2;
  localparam logic [1:0] IDX_LOOPCODE     = 2'h3;
  localparam logic [7:0] IDX_TX_STATUS    = 8'hF0;

  // Address slicing of the word index
  localparam int unsigned ADDR_IDX_LO  = 2;
  localparam int unsigned ADDR_IDX_HI  = 9;
  localparam int unsigned ADDR_REG_LO  = 2;
  localparam int unsigned ADDR_REG_HI  = 3;
  localparam int unsigned ADDR_PAD_LO  = 4;
  localparam int unsigned ADDR_PAD_HI  = 5;
  localparam int unsigned ADDR_CH_LO   = 6;
  localparam int unsigned ADDR_CH_HI   = 9;
  localparam int unsigned ADDR_TOP_LO  = 10;

  // ****************************************************************
  // Reset values and writable masks
  // ****************************************************************
  localparam logic [7:0] CFG_RESET         = 8'h00;
  localparam logic [7:0] MASK_PATTERN_TYPE = 8'h80;
  localparam logic [7:0] MASK_TERM_JITTER  = 8'hFF;
  localparam logic [7:0] MASK_TEST_POWER   = 8'hFF;
  localparam logic [7:0] MASK_LOOPCODE     = 8'hFE;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned B_PATTERN_TYPE = 7;

  localparam int unsigned B_RX_TERM      = 7;
  localparam int unsigned B_TX_TERM      = 6;
  localparam int unsigned B_IMPED_HI     = 5;
  localparam int unsigned B_IMPED_LO     = 4;
  localparam int unsigned B_RX_JA        = 3;
  localparam int unsigned B_TX_JA        = 2;
  localparam int unsigned B_JA_BW        = 1;
  localparam int unsigned B_FIFO_DEPTH   = 0;

  localparam int unsigned B_PAT_INVERT   = 7;
  localparam int unsigned B_TEST_HI      = 6;
  localparam int unsigned B_TEST_LO      = 4;
  localparam int unsigned B_TX_POWER     = 3;
  localparam int unsigned B_LOOP_HI      = 2;
  localparam int unsigned B_LOOP_LO      = 0;

  localparam int unsigned B_DETECT_HI    = 7;
  localparam int unsigned B_DETECT_LO    = 6;
  localparam int unsigned B_CODING       = 5;
  localparam int unsigned B_RES_HI       = 4;
  localparam int unsigned B_RES_LO       = 3;
  localparam int unsigned B_INS_VIOL     = 2;
  localparam int unsigned B_INS_ERR      = 1;

  localparam int unsigned B_STAT_PIN     = 16;

  // ****************************************************************
  // Field encodings
  // ****************************************************************
  // Effective jitter bandwidth
  localparam logic [1:0] JBW_10HZ  = 2'h0;
  localparam logic [1:0] JBW_1P5HZ = 2'h1;
  localparam logic [1:0] JBW_3HZ   = 2'h2;

  // Effective line code
  localparam logic [1:0] LCODE_HDB3 = 2'h0;
  localparam logic [1:0] LCODE_B8ZS = 2'h1;
  localparam logic [1:0] LCODE_AMI  = 2'h2;
  localparam logic [1:0] LCODE_DUAL = 2'h3;

  // Attenuator FIFO depth in bits; delay is half the depth
  localparam int unsigned FIFO_SHALLOW = 32;
  localparam int unsigned FIFO_DEEP    = 64;
  localparam logic [5:0]  DLY_SHALLOW  = 6'(FIFO_SHALLOW / 2);
  localparam logic [5:0]  DLY_DEEP     = 6'(FIFO_DEEP / 2);

  // AHB-Lite
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage

// [tb/lucc_regs_asserts.sv]
// Concurrent checks on the ports of the channel control bank
`timescale 1ns/1ps
module lucc_regs_asserts #(
  parameter int unsigned NUM_CH = 14
) (
  input wire logic                        hclk,
  input wire logic                        hresetn,
  input wire logic                        hsel,
  input wire logic [1:0]                  htrans,
  input wire logic                        hwrite,
  input wire logic                        hready,
  input wire logic [lucc_pkg::DATA_W-1:0] hrdata,
  input wire logic                        hreadyout,
  input wire logic                        hresp,
  input wire logic                        tx_power_pin,
  input wire logic                        tx_clock,
  input wire logic [NUM_CH-1:0]           e1_mode,
  input wire logic [NUM_CH-1:0]           single_rail,
  input wire logic [2*NUM_CH-1:0]         jitter_bw_code,
  input wire logic [NUM_CH-1:0]           fifo_depth_select,
  input wire logic [6*NUM_CH-1:0]         ja_fifo_delay,
  input wire logic [NUM_CH-1:0]           tx_power_enable,
  input wire logic [2*NUM_CH-1:0]         line_code,
  input wire logic [NUM_CH-1:0]           insert_violation_pulse,
  input wire logic [NUM_CH-1:0]           insert_bit_error_pulse
);
  import lucc_pkg::*;
  logic       tck_d_ff;
  logic [3:0] tck_age_ff;

  // Cycles since raw transmit clock rise
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tck_d_ff   <= 1'b0;
      tck_age_ff <= 4'hF;
    end else begin
      tck_d_ff <= tx_clock;
      if (tx_clock && !tck_d_ff) tck_age_ff <= 4'h0;
      else if (tck_age_ff != 4'hF) tck_age_ff <= tck_age_ff + 4'h1;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence rd_req_s; hsel && hready && htrans[1] && !hwrite; endsequence
  sequence wr_req_s; hsel && hready && htrans[1] && hwrite; endsequence
  sequence rd_wait_s; !hreadyout ##1 hreadyout; endsequence

  okay_resp_a: assert property (hresp == HRESP_OKAY)
    else $error("bad response");
  read_wait_a: assert property (rd_req_s |=> rd_wait_s)
    else $error("read wait wrong");
  write_fast_a: assert property (wr_req_s |=> hreadyout)
    else $error("write stalled");
  upper_zero_a: assert property (hrdata[31:17] == 15'h0)
    else $error("unused read bits set");
  viol_once_a: assert property (|insert_violation_pulse |=>
    (insert_violation_pulse & $past(insert_violation_pulse)) == '0)
    else $error("violation pulse long");
  err_once_a: assert property (|insert_bit_error_pulse |=>
    (insert_bit_error_pulse & $past(insert_bit_error_pulse)) == '0)
    else $error("error pulse long");
  pulse_tx_clock_a: assert property (|(insert_violation_pulse | insert_bit_error_pulse)
    |-> tck_age_ff <= 4'h8)
    else $error("pulse without clock");
  power_gate_a: assert property (!tx_power_pin [*8] |=> tx_power_enable == '0)
    else $error("powered with pin low");
  line_code_a: assert property (!single_rail[0] |=> line_code[1:0] == LCODE_DUAL)
    else $error("dual rail coded");
  t1_bw_a: assert property (!e1_mode[0] |=> jitter_bw_code[1:0] == JBW_3HZ)
    else $error("T1 bandwidth");
  fifo_delay_a: assert property (1'b1 |=> ja_fifo_delay[5:0] ==
    ($past(fifo_depth_select[0]) ? DLY_DEEP : DLY_SHALLOW))
    else $error("fifo delay wrong");
endmodule // lucc_regs_asserts

bind lucc_regs lucc_regs_asserts #(.NUM_CH(NUM_CH)) u_lucc_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .tx_power_pin(tx_power_pin), .tx_clock(tx_clock), .e1_mode(e1_mode),
  .single_rail(single_rail), .jitter_bw_code(jitter_bw_code),
  .fifo_depth_select(fifo_depth_select), .ja_fifo_delay(ja_fifo_delay),
  .tx_power_enable(tx_power_enable), .line_code(line_code),
  .insert_violation_pulse(insert_violation_pulse),
  .insert_bit_error_pulse(insert_bit_error_pulse));

// [tb/lucc_host.sv]
// Host model: single-word AHB-Lite master that configures the bank
`timescale 1ns/1ps
module lucc_host (
  input  wire logic                        hclk,
  input  wire logic                        hready,
  input  wire logic [lucc_pkg::DATA_W-1:0] hrdata,
  output logic                             hsel,
  output logic      [lucc_pkg::ADDR_W-1:0] haddr,
  output logic      [1:0]                  htrans,
  output logic                             hwrite,
  output logic      [2:0]                  hsize,
  output logic      [lucc_pkg::DATA_W-1:0] hwdata
);
  import lucc_pkg::*;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Holds each phase until hready
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule // lucc_host

// [tb/lucc_regs_tb.sv]
// Self-checking bench for the line unit channel control bank
`timescale 1ns/1ps
module lucc_regs_tb;
  import lucc_pkg::*;
  localparam int N = 14;
  logic           hclk = 1'b0;
  logic           hresetn = 1'b0;
  logic           tx_clock = 1'b0;
  logic           hsel, hwrite, hreadyout, hresp, tx_power_pin;
  logic [1:0]     htrans;
  logic [2:0]     hsize;
  logic [31:0]    haddr, hwdata, hrdata, rnd, q, e;
  logic [N-1:0]   e1_mode, single_rail, rx_term_select, tx_term_select, fifo_depth_select;
  logic [N-1:0]   rx_jitter_atten_enable, tx_jitter_atten_enable, pattern_invert;
  logic [N-1:0]   pattern_type_select, tx_power_enable;
  logic [N-1:0]   insert_violation_pulse, insert_bit_error_pulse;
  logic [2*N-1:0] line_impedance_select, jitter_bw_code, loop_code_detect_select;
  logic [2*N-1:0] line_code, rx_resistor_select;
  logic [3*N-1:0] tx_test_pattern_select, loopback_select;
  logic [6*N-1:0] ja_fifo_delay;
  logic [7:0]     shadow [N][4] = '{default: 8'h00};
  logic [7:0]     d [4];
  logic [7:0]     masks [4] = '{MASK_PATTERN_TYPE, MASK_TERM_JITTER, MASK_TEST_POWER, MASK_LOOPCODE};
  int             bad_count = 0, checked = 0, cycles = 0, viol_seen = 0, err_seen = 0, ch;

  lucc_regs #(.NUM_CH(N)) i_dut (.hready(hreadyout), .*);
  lucc_host i_host (.hready(hreadyout), .*);

  always #5 hclk = ~hclk;
  always #43 tx_clock = ~tx_clock;

  always @(negedge hclk) begin
    cycles++;
    viol_seen += $countones(insert_violation_pulse);
    err_seen += $countones(insert_bit_error_pulse);
    if (cycles == 30000) begin
      bad_count++;
      give_verdict();
    end
  end

  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [1:0] exp_lcode(logic sr, logic e1, logic ami);
    if (!sr) return LCODE_DUAL;
    if (ami) return LCODE_AMI;
    return e1 ? LCODE_HDB3 : LCODE_B8ZS;
  endfunction

  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(int c, int r, logic [7:0] v);
    i_host.xfer(32'(c * 64 + r * 4), 1'b1, {24'h0, v}, q);
    shadow[c][r] = v & masks[r];
  endtask
  task automatic rd_check(int c, int r);
    i_host.xfer(32'(c * 64 + r * 4), 1'b0, 32'h0, q);
    check("readback", {24'h0, shadow[c][r]}, q);
  endtask
  task automatic check_ports(int c);
    logic [7:0] a, b, t;
    a = shadow[c][1];
    b = shadow[c][2];
    t = shadow[c][3];
    repeat (2) @(posedge hclk);
    @(negedge hclk);
    check("term_jitter", {a[7:2], a[0]}, {rx_term_select[c], tx_term_select[c],
      line_impedance_select[2*c+:2], rx_jitter_atten_enable[c],
      tx_jitter_atten_enable[c], fifo_depth_select[c]});
    check("bandwidth", e1_mode[c] ? {1'b0, a[1]} : JBW_3HZ, jitter_bw_code[2*c+:2]);
    check("fifo delay", a[0] ? DLY_DEEP : DLY_SHALLOW, ja_fifo_delay[6*c+:6]);
    check("test_loop", {b[7:4], b[2:0]}, {pattern_invert[c],
      tx_test_pattern_select[3*c+:3], loopback_select[3*c+:3]});
    check("power", b[3] & tx_power_pin, tx_power_enable[c]);
    check("detect_res", {t[7:6], t[4:3]},
      {loop_code_detect_select[2*c+:2], rx_resistor_select[2*c+:2]});
    check("line code", exp_lcode(single_rail[c], e1_mode[c], t[5]), line_code[2*c+:2]);
    check("pattern type", shadow[c][0][7], pattern_type_select[c]);
  endtask
  task automatic check_all();
    for (int c = 0; c < N; c++) begin
      for (int r = 0; r < 4; r++) rd_check(c, r);
      check_ports(c);
    end
  endtask
  task automatic check_status();
    e = 32'h0;
    for (int c = 0; c < N; c++) e[c] = shadow[c][2][3] & tx_power_pin;
    e[B_STAT_PIN] = tx_power_pin;
    i_host.xfer(32'h0000_03C0, 1'b0, 32'h0, q);
    check("status", e, q);
  endtask
  task automatic wait_tck(int n);
    repeat (n) @(posedge tx_clock);
    repeat (8) @(posedge hclk);
    @(negedge hclk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    rnd = 32'hE7B4BAE3;
    tx_power_pin = 1'b1;
    e1_mode = '0;
    single_rail = '0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    e1_mode <= {rnd[N-1:1], 1'b0};
    single_rail <= {rnd[2*N-1:N+1], 1'b0};
    check_all();
    // Code fields walk all encodings; insert bits held at zero, other bits random
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      ch = int'(rnd % N);
      rnd = lfsr(rnd);
      d = '{rnd[31:24], rnd[7:0], rnd[15:8], rnd[23:16]};
      d[1][5:4] = 2'(i);
      d[2][6:4] = 3'(i);
      d[2][2:0] = 3'(i);
      d[3][7:6] = 2'(i);
      d[3][4:3] = 2'(i);
      d[3][2:1] = 2'b00;
      for (int r = 0; r < 4; r++) wr(ch, r, d[r]);
      for (int r = 0; r < 4; r++) rd_check(ch, r);
      check_ports(ch);
    end
    i_host.xfer(32'h0000_0010, 1'b1, 32'h0000_00FF, q);
    i_host.xfer(32'h0000_0010, 1'b0, 32'h0, q);
    check("gap", 32'h0, q);
    i_host.xfer(32'h0000_0400, 1'b0, 32'h0, q);
    check("outside", 32'h0, q);
    check_status();
    tx_power_pin <= 1'b0;
    repeat (12) @(posedge hclk);
    check("pin off", '0, tx_power_enable);
    check_status();
    tx_power_pin <= 1'b1;
    repeat (12) @(posedge hclk);
    ch = int'(rnd % N);
    wr(ch, 3, 8'h00);
    wait_tck(2);
    wr(ch, 3, 8'h04);
    wait_tck(3);
    check("violation count", 1, viol_seen);
    check("error count", 0, err_seen);
    wr(ch, 3, 8'h06);
    wait_tck(3);
    check("held violation", 1, viol_seen);
    check("error count", 1, err_seen);
    check_all();
    give_verdict();
  end
endmodule // lucc_regs_tb
